//--- mrs_defines.svh
// offsets, codes, field positions and timing counts of the status slave
`ifndef MRS_DEFINES_SVH
`define MRS_DEFINES_SVH

`define MRS_CLK_HZ          200000000
`define MRS_BAUD            19200
`define MRS_GAP_MS          20
`define MRS_CMD_GAP_MS      50
`define MRS_BIT_CYCLES      (`MRS_CLK_HZ / `MRS_BAUD)
`define MRS_GAP_CYCLES      (`MRS_CLK_HZ / 1000 * `MRS_GAP_MS)

`define MRS_ADDR_DEFAULT    8'h01
`define MRS_FUNC_READ_HOLD  8'h03
`define MRS_REQ_LEN         4'h8
`define MRS_REPLY_OVERHEAD  8'h05
`define MRS_MAX_COUNT       16'h007D
`define MRS_CRC_INIT        16'hFFFF
`define MRS_CRC_POLY        16'hA001

`define MRS_TABLE_DEPTH     16
`define MRS_TABLE_USED      16'h000E
`define MRS_IDX_UNMAPPED    4'hF
`define MRS_REG_EPOCH_HIGH  4'h4
`define MRS_REG_EPOCH_LOW   4'h5
`define MRS_REG_FAULTS      4'h7
`define MRS_REG_HEALTH      4'h9
`define MRS_REG_SPEED       4'hA
`define MRS_REG_DIRECTION   4'hB
`define MRS_REG_CURRENT     4'hC
`define MRS_REG_BATTERY     4'hD

`define MRS_FAULT_CHARGE_BIT 1
`define MRS_FAULT_MOTOR_BIT  2
`define MRS_FAULT_OOR_BIT    3

`define MRS_HC_HEALTHY      16'h0000
`define MRS_HC_STALL        16'h0001
`define MRS_HC_SUPPLY36     16'h0002
`define MRS_HC_MOTOR_COMM   16'h0003
`define MRS_HC_CHARGE_COMM  16'h0004
`define MRS_HC_BATT_LIMIT   16'h0005
`define MRS_HC_HIGH_CURRENT 16'h0010
`define MRS_HC_LOW_BATTERY  16'h0020
`define MRS_HC_TEMP         16'h0030
`define MRS_HC_SUPPLY5      16'h0040
`define MRS_HC_GNSS_COMM    16'h0050
`define MRS_HC_ACQUIRING    16'h0100

`define MRS_DIR_STOPPED     2'h0
`define MRS_DIR_FORWARD     2'h1
`define MRS_DIR_REVERSE     2'h3

`endif

//--- mrs_pkg.sv
// types shared by the status slave files
`default_nettype none
package mrs_pkg;
  typedef enum logic [4:0] {
    SQ_RX    = 5'b00001,
    SQ_CHECK = 5'b00010,
    SQ_FETCH = 5'b00100,
    SQ_LOAD  = 5'b01000,
    SQ_SEND  = 5'b10000
  } mrs_seq_e;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } mrs_rx_e;

  typedef struct packed {
    logic batt_limit;
    logic stall_recovery_sequence;
    logic supply36_oor;
    logic motor_comm_err;
    logic charge_comm_err;
    logic high_motor_current;
    logic temp_oor;
    logic supply5_oor;
    logic gnss_comm_err;
    logic acquiring_gnss;
    logic low_battery;
    logic out_of_range_fault;
  } mrs_cond_s;

  typedef struct packed {
    logic [15:0] speed_centi_rpm;
    logic [1:0]  direction;
    logic [15:0] current_ma;
  } mrs_motor_s;
endpackage
`default_nettype wire

//--- mrs_reg_table.sv
// holding register snapshot memory with registered read port
`default_nettype none
module mrs_reg_table #(
  parameter int DEPTH = 16,
  parameter int W     = 16
)(
  input  wire logic                     mclk,
  input  wire logic                     rst,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [W-1:0]             wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [W-1:0]             rd_data
);
  logic [W-1:0] mem [DEPTH];
  logic [W-1:0] next_rd_data;

  always_comb begin
    next_rd_data = mem[rd_addr];
  end

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= next_rd_data;
    end
  end
endmodule
`default_nettype wire

//--- mrs_status_slave.sv
// serial read-holding-register slave reporting controller status
`include "mrs_defines.svh"
`default_nettype none
// Summary of operation
// - serial 19200 baud, 8 data bits, 1 stop, no parity, no flow control
// - slave implements function 3, read holding registers
// - a well formed read request gets a reply with register contents
// - reply: address, function 3, byte count, two bytes per register, crc
// - slave address is a stored default that can be reloaded in the field
// - register addresses are zero based, first entry at 0
// - registers 4 and 5 give epoch seconds high and low halves
// - epoch value is loaded from the positioning receiver
// - register 7 reads 0 when healthy, nonzero on a charge comm, motor comm or out of range fault
// - lost subsystem flagged in status, last values kept
// - register 9 normal codes 0, 32, 1 and 256
// - register 9 red codes 2, 3, 4 and 5
// - register 9 yellow codes 16, 48, 64 and 80
// - register 10 is motor speed in hundredths of rpm
// - register 11 direction: 0 stopped, 1 forward, 3 reverse
// - status bit 1 charge comm, bit 2 motor comm, bit 3 analog range
// - register 12 motor current in mA, 13 battery in tenths of volts
module mrs_status_slave import mrs_pkg::*; #(
  parameter int         BIT_CYCLES   = `MRS_BIT_CYCLES,
  parameter int         GAP_CYCLES   = `MRS_GAP_CYCLES,
  parameter logic [7:0] ADDR_DEFAULT = `MRS_ADDR_DEFAULT
)(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        rxd,
  output logic             txd,
  output logic             tx_enable,
  input  wire logic        addr_load,
  input  wire logic [7:0]  addr_value,
  output logic      [7:0]  slave_addr,
  input  wire logic [31:0] epoch_seconds,
  input  wire logic        epoch_valid,
  input  wire mrs_motor_s  motor,
  input  wire logic        motor_valid,
  input  wire logic [15:0] battery_dv,
  input  wire logic        charge_valid,
  input  wire mrs_cond_s   cond
);
  localparam int BW = $clog2(BIT_CYCLES + 1);
  localparam int GW = $clog2(GAP_CYCLES + 1);
  localparam int AW = $clog2(`MRS_TABLE_DEPTH);

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `MRS_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // single code for the most urgent condition: battery limit, stall, other red, yellow, then normal
  function automatic logic [15:0] health_code(input mrs_cond_s c);
    if (c.batt_limit)                   return `MRS_HC_BATT_LIMIT;
    else if (c.stall_recovery_sequence) return `MRS_HC_STALL;
    else if (c.supply36_oor)            return `MRS_HC_SUPPLY36;
    else if (c.motor_comm_err)          return `MRS_HC_MOTOR_COMM;
    else if (c.charge_comm_err)         return `MRS_HC_CHARGE_COMM;
    else if (c.high_motor_current)      return `MRS_HC_HIGH_CURRENT;
    else if (c.temp_oor)                return `MRS_HC_TEMP;
    else if (c.supply5_oor)             return `MRS_HC_SUPPLY5;
    else if (c.gnss_comm_err)           return `MRS_HC_GNSS_COMM;
    else if (c.acquiring_gnss)          return `MRS_HC_ACQUIRING;
    else if (c.low_battery)             return `MRS_HC_LOW_BATTERY;
    else                                return `MRS_HC_HEALTHY;
  endfunction

  // ---- held subsystem values and table refresh
  logic [31:0] epoch;
  logic [31:0] next_epoch;
  mrs_motor_s  mot;
  mrs_motor_s  next_mot;
  logic [15:0] batt;
  logic [15:0] next_batt;
  logic [7:0]  next_slave_addr;
  logic [AW-1:0] ref_idx;
  logic [AW-1:0] next_ref_idx;
  logic [15:0] faults;
  logic [15:0] ref_word;

  always_comb begin
    next_epoch = epoch_valid ? epoch_seconds : epoch;
    next_mot = motor_valid ? motor : mot;
    next_batt = charge_valid ? battery_dv : batt;
    next_slave_addr = addr_load ? addr_value : slave_addr;
    next_ref_idx = ref_idx + 1'b1;
    faults = '0;
    faults[`MRS_FAULT_CHARGE_BIT] = cond.charge_comm_err;
    faults[`MRS_FAULT_MOTOR_BIT] = cond.motor_comm_err;
    faults[`MRS_FAULT_OOR_BIT] = cond.out_of_range_fault;
    case (ref_idx)
      `MRS_REG_EPOCH_HIGH: ref_word = epoch[31:16];
      `MRS_REG_EPOCH_LOW:  ref_word = epoch[15:0];
      `MRS_REG_FAULTS:     ref_word = faults;
      `MRS_REG_HEALTH:     ref_word = health_code(cond);
      `MRS_REG_SPEED:      ref_word = mot.speed_centi_rpm;
      `MRS_REG_DIRECTION:  ref_word = {14'h0000, mot.direction};
      `MRS_REG_CURRENT:    ref_word = mot.current_ma;
      `MRS_REG_BATTERY:    ref_word = batt;
      default:             ref_word = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      epoch <= '0;
      mot <= '0;
      batt <= '0;
      slave_addr <= ADDR_DEFAULT;
      ref_idx <= '0;
    end else begin
      epoch <= next_epoch;
      mot <= next_mot;
      batt <= next_batt;
      slave_addr <= next_slave_addr;
      ref_idx <= next_ref_idx;
    end
  end

  // ---- receiver: samples mid-bit, one byte strobe per good stop bit
  mrs_rx_e     rx_st;
  mrs_rx_e     next_rx_st;
  logic [BW-1:0] rx_cnt;
  logic [BW-1:0] next_rx_cnt;
  logic [2:0]  rx_bit;
  logic [2:0]  next_rx_bit;
  logic [7:0]  rx_sh;
  logic [7:0]  next_rx_sh;
  logic        rx_stb;
  logic        next_rx_stb;
  logic        rx_ferr;
  logic        next_rx_ferr;
  logic [GW-1:0] gap_cnt;
  logic [GW-1:0] next_gap_cnt;
  logic        gap_hit;

  always_comb begin
    next_rx_st = rx_st;
    next_rx_cnt = rx_cnt + 1'b1;
    next_rx_bit = rx_bit;
    next_rx_sh = rx_sh;
    next_rx_stb = 1'b0;
    next_rx_ferr = 1'b0;
    case (rx_st)
      RX_IDLE: begin
        next_rx_cnt = '0;
        if (!rxd) begin
          next_rx_st = RX_START;
        end
      end
      RX_START: begin
        if (rx_cnt == BW'(BIT_CYCLES / 2)) begin
          next_rx_cnt = '0;
          next_rx_bit = '0;
          next_rx_st = rxd ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (rx_cnt == BW'(BIT_CYCLES - 1)) begin
          next_rx_cnt = '0;
          next_rx_sh = {rxd, rx_sh[7:1]};
          next_rx_bit = rx_bit + 1'b1;
          if (rx_bit == 3'h7) begin
            next_rx_st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (rx_cnt == BW'(BIT_CYCLES - 1)) begin
          next_rx_st = RX_IDLE;
          next_rx_stb = rxd;
          next_rx_ferr = !rxd;
        end
      end
      default: next_rx_st = RX_IDLE;
    endcase
    // idle time counts only while the line rests high between characters
    if (rx_st != RX_IDLE || !rxd) begin
      next_gap_cnt = '0;
    end else if (gap_hit) begin
      next_gap_cnt = gap_cnt;
    end else begin
      next_gap_cnt = gap_cnt + 1'b1;
    end
  end

  assign gap_hit = (gap_cnt == GW'(GAP_CYCLES));

  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_st <= RX_IDLE;
      rx_cnt <= '0;
      rx_bit <= '0;
      rx_sh <= '0;
      rx_stb <= 1'b0;
      rx_ferr <= 1'b0;
      gap_cnt <= '0;
    end else begin
      rx_st <= next_rx_st;
      rx_cnt <= next_rx_cnt;
      rx_bit <= next_rx_bit;
      rx_sh <= next_rx_sh;
      rx_stb <= next_rx_stb;
      rx_ferr <= next_rx_ferr;
      gap_cnt <= next_gap_cnt;
    end
  end

  // ---- frame check and reply sequencer
  mrs_seq_e    seq;
  mrs_seq_e    next_seq;
  logic [7:0]  frm [6];
  logic [7:0]  next_frm [6];
  logic [3:0]  frm_len;
  logic [3:0]  next_frm_len;
  logic        frm_bad;
  logic        next_frm_bad;
  logic [15:0] rx_crc;
  logic [15:0] next_rx_crc;
  logic [7:0]  tx_idx;
  logic [7:0]  next_tx_idx;
  logic [7:0]  tx_total;
  logic [7:0]  next_tx_total;
  logic [15:0] tx_crc;
  logic [15:0] next_tx_crc;
  logic [9:0]  tx_sh;
  logic [9:0]  next_tx_sh;
  logic [3:0]  tx_bit;
  logic [3:0]  next_tx_bit;
  logic [BW-1:0] tx_cnt;
  logic [BW-1:0] next_tx_cnt;
  logic [15:0] req_start;
  logic [15:0] req_count;
  logic        req_ok;
  logic [7:0]  widx;
  logic [15:0] word_addr;
  logic [AW-1:0] rd_addr;
  logic [15:0] rd_data;
  logic [7:0]  tx_byte;

  assign req_start = {frm[2], frm[3]};
  assign req_count = {frm[4], frm[5]};
  // residue of zero over all eight bytes means the crc matched
  assign req_ok = frm_len == `MRS_REQ_LEN && !frm_bad && rx_crc == 16'h0000
                  && frm[0] == slave_addr
                  && frm[1] == `MRS_FUNC_READ_HOLD
                  && req_count != 16'h0000 && req_count <= `MRS_MAX_COUNT;
  assign widx = tx_idx - 8'h03;
  assign word_addr = req_start + {9'h000, widx[7:1]};
  assign rd_addr = (word_addr < `MRS_TABLE_USED) ? word_addr[AW-1:0] : `MRS_IDX_UNMAPPED;

  always_comb begin
    if (tx_idx == 8'h00) begin
      tx_byte = slave_addr;
    end else if (tx_idx == 8'h01) begin
      tx_byte = `MRS_FUNC_READ_HOLD;
    end else if (tx_idx == 8'h02) begin
      tx_byte = tx_total - `MRS_REPLY_OVERHEAD;
    end else if (tx_idx == tx_total - 8'h02) begin
      tx_byte = tx_crc[7:0];
    end else if (tx_idx == tx_total - 8'h01) begin
      tx_byte = tx_crc[15:8];
    end else begin
      tx_byte = widx[0] ? rd_data[7:0] : rd_data[15:8];
    end
  end

  always_comb begin
    next_seq = seq;
    next_frm = frm;
    next_frm_len = frm_len;
    next_frm_bad = frm_bad;
    next_rx_crc = rx_crc;
    next_tx_idx = tx_idx;
    next_tx_total = tx_total;
    next_tx_crc = tx_crc;
    next_tx_sh = tx_sh;
    next_tx_bit = tx_bit;
    next_tx_cnt = tx_cnt;
    case (seq)
      SQ_RX: begin
        if (rx_stb) begin
          if (frm_len < 4'h6) begin
            next_frm[frm_len[2:0]] = rx_sh;
          end
          if (frm_len == `MRS_REQ_LEN) begin
            next_frm_bad = 1'b1;
          end else begin
            next_frm_len = frm_len + 1'b1;
          end
          next_rx_crc = crc_step(rx_crc, rx_sh);
        end
        if (rx_ferr) begin
          next_frm_bad = 1'b1;
        end
        if (gap_hit && frm_len != 4'h0) begin
          next_seq = SQ_CHECK;
        end
      end
      SQ_CHECK: begin
        next_frm_len = '0;
        next_frm_bad = 1'b0;
        next_rx_crc = `MRS_CRC_INIT;
        next_tx_idx = '0;
        next_tx_crc = `MRS_CRC_INIT;
        next_tx_total = `MRS_REPLY_OVERHEAD + {req_count[6:0], 1'b0};
        next_seq = req_ok ? SQ_FETCH : SQ_RX;
      end
      SQ_FETCH: next_seq = SQ_LOAD;
      SQ_LOAD: begin
        next_tx_sh = {1'b1, tx_byte, 1'b0};
        next_tx_bit = '0;
        next_tx_cnt = '0;
        if (tx_idx < tx_total - 8'h02) begin
          next_tx_crc = crc_step(tx_crc, tx_byte);
        end
        next_seq = SQ_SEND;
      end
      SQ_SEND: begin
        next_tx_cnt = tx_cnt + 1'b1;
        if (tx_cnt == BW'(BIT_CYCLES - 1)) begin
          next_tx_cnt = '0;
          next_tx_sh = {1'b1, tx_sh[9:1]};
          next_tx_bit = tx_bit + 1'b1;
          if (tx_bit == 4'h9) begin
            next_tx_idx = tx_idx + 1'b1;
            next_seq = (tx_idx == tx_total - 8'h01) ? SQ_RX : SQ_FETCH;
          end
        end
      end
      default: next_seq = SQ_RX;
    endcase
    // half duplex: anything heard while replying is thrown away
    if (seq != SQ_RX && seq != SQ_CHECK) begin
      next_frm_len = '0;
      next_frm_bad = 1'b0;
      next_rx_crc = `MRS_CRC_INIT;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      seq <= SQ_RX;
      for (int i = 0; i < 6; i++) begin
        frm[i] <= '0;
      end
      frm_len <= '0;
      frm_bad <= 1'b0;
      rx_crc <= `MRS_CRC_INIT;
      tx_idx <= '0;
      tx_total <= '0;
      tx_crc <= `MRS_CRC_INIT;
      tx_sh <= '1;
      tx_bit <= '0;
      tx_cnt <= '0;
    end else begin
      seq <= next_seq;
      frm <= next_frm;
      frm_len <= next_frm_len;
      frm_bad <= next_frm_bad;
      rx_crc <= next_rx_crc;
      tx_idx <= next_tx_idx;
      tx_total <= next_tx_total;
      tx_crc <= next_tx_crc;
      tx_sh <= next_tx_sh;
      tx_bit <= next_tx_bit;
      tx_cnt <= next_tx_cnt;
    end
  end

  assign txd = tx_sh[0];
  // driver stays on across the fetch gap so the line never floats mid-reply
  assign tx_enable = (seq == SQ_LOAD) || (seq == SQ_SEND)
                     || (seq == SQ_FETCH && tx_idx != 8'h00);

  mrs_reg_table #(
    .DEPTH (`MRS_TABLE_DEPTH),
    .W     (16)
  ) u_table (
    .mclk    (mclk),
    .rst     (rst),
    .wr_en   (1'b1),
    .wr_addr (ref_idx),
    .wr_data (ref_word),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );
endmodule
`default_nettype wire

//--- mrs_slave_properties.sv
// assertions on the serial pins and the address port of the status slave
`default_nettype none
module mrs_slave_checker #(
  parameter int         BIT_CYCLES   = 16,
  parameter int         GAP_CYCLES   = 200,
  parameter logic [7:0] ADDR_DEFAULT = 8'h01
)(
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       rxd,
  input wire logic       txd,
  input wire logic       tx_enable,
  input wire logic       addr_load,
  input wire logic [7:0] addr_value,
  input wire logic [7:0] slave_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // run lengths; wide so a run never wraps
  logic [31:0] low_run;
  logic [31:0] quiet_run;
  logic [31:0] next_low_run;
  logic [31:0] next_quiet_run;
  always_comb begin
    next_low_run   = txd ? 32'h0000_0000 : low_run + 32'h0000_0001;
    next_quiet_run = rxd ? quiet_run + 32'h0000_0001 : 32'h0000_0000;
    if (rst) begin
      next_low_run   = 32'h0000_0000;
      next_quiet_run = 32'h0000_0000;
    end
  end
  always_ff @(posedge mclk) begin
    low_run   <= next_low_run;
    quiet_run <= next_quiet_run;
  end
  sequence s_start_bit;
    txd ##1 !txd [*8];
  endsequence
  sequence s_stop_bit;
    txd && $past(txd, 8);
  endsequence
  property p_release;
    $fell(rst) |-> slave_addr == ADDR_DEFAULT && txd && !tx_enable;
  endproperty
  a_release: assert property (p_release) else $error("bad state after reset");
  property p_addr_load;
    addr_load |=> slave_addr == $past(addr_value);
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("address not loaded");
  property p_addr_hold;
    !addr_load |=> $stable(slave_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address changed unasked");
  property p_idle_high;
    !tx_enable |-> txd;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line low while not sending");
  property p_bit_time;
    $rose(txd) |-> low_run != 0 && low_run % BIT_CYCLES == 0;
  endproperty
  a_bit_time: assert property (p_bit_time) else $error("low run not whole bits");
  property p_reply_start;
    $rose(tx_enable) |-> s_start_bit;
  endproperty
  a_reply_start: assert property (p_reply_start) else $error("reply start bit wrong");
  property p_reply_end;
    $fell(tx_enable) |-> s_stop_bit;
  endproperty
  a_reply_end: assert property (p_reply_end) else $error("driver off before stop bit");
  property p_frame_gap;
    $rose(tx_enable) |-> quiet_run >= GAP_CYCLES
      && quiet_run <= GAP_CYCLES + 10 * BIT_CYCLES + 8;
  endproperty
  a_frame_gap: assert property (p_frame_gap) else $error("reply not after idle gap");
endmodule
bind mrs_status_slave mrs_slave_checker #(
  .BIT_CYCLES  (BIT_CYCLES),
  .GAP_CYCLES  (GAP_CYCLES),
  .ADDR_DEFAULT(ADDR_DEFAULT)
) u_chk (
  .mclk(mclk), .rst(rst), .rxd(rxd), .txd(txd), .tx_enable(tx_enable),
  .addr_load(addr_load), .addr_value(addr_value), .slave_addr(slave_addr)
);
`default_nettype wire

//--- mrs_master_model.sv
// serial master that sends read requests and gathers replies
`default_nettype none
module mrs_master_model #(
  parameter int BIT_CYCLES = 16,
  parameter int GAP_CYCLES = 200
)(
  input  wire logic mclk,
  output logic      rxd,
  input  wire logic txd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rxd = 1'b1;
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk);
      #1;
    end
  endtask
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  // lsb first, one stop, no parity
  task automatic send_byte(input logic [7:0] b);
    rxd = 1'b0;
    tick(BIT_CYCLES);
    for (int i = 0; i < 8; i++) begin
      rxd = b[i];
      tick(BIT_CYCLES);
    end
    rxd = 1'b1;
    tick(BIT_CYCLES);
  endtask
  task automatic send_req(input logic [7:0] a, input logic [7:0] f, input logic [15:0] st,
                          input logic [15:0] cnt, input logic bad, input int pause);
    logic [7:0]  q[$];
    logic [15:0] c;
    tick(GAP_CYCLES * 5 / 2);
    q = {a, f, st[15:8], st[7:0], cnt[15:8], cnt[7:0]};
    c = crc16(q) ^ {15'h0000, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i]) begin
      send_byte(q[i]);
      if (i == 3) tick(pause);
    end
  endtask
  task automatic get_byte(input int lim, output logic [7:0] b, output bit ok);
    int n;
    n = 0;
    ok = 0;
    while (txd === 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
    if (txd !== 1'b0) return;
    tick(BIT_CYCLES / 2);
    for (int i = 0; i < 8; i++) begin
      tick(BIT_CYCLES);
      b[i] = txd;
    end
    tick(BIT_CYCLES);
    ok = (txd === 1'b1);
  endtask
  // a byte gap of three bit times ends the reply
  task automatic get_reply(output logic [7:0] r[$]);
    logic [7:0] b;
    bit         ok;
    int         lim;
    r = {};
    lim = GAP_CYCLES + 20 * BIT_CYCLES;
    do begin
      get_byte(lim, b, ok);
      if (ok) r.push_back(b);
      lim = 3 * BIT_CYCLES;
    end while (ok);
  endtask
endmodule
`default_nettype wire

//--- tb_modbus_rtu_status_slave.sv
// self-checking bench of the serial status slave
`default_nettype none
module tb_modbus_rtu_status_slave import mrs_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BITC = 16;
  localparam int GAPC = 200;
  logic        mclk, rst, rxd, txd, tx_enable, addr_load, epoch_valid, motor_valid, charge_valid;
  logic [7:0]  addr_value, slave_addr;
  logic [31:0] epoch_seconds;
  logic [15:0] battery_dv, hc_exp;
  mrs_motor_s  motor, mot_held;
  mrs_cond_s   cond;
  int          errors = 0, tests_run = 0, cycles = 0, rlen;
  logic [15:0] words[$];
  logic [1:0]  dirs[3] = '{2'h0, 2'h1, 2'h3};
  logic [15:0] hcode[13] = '{16'h0005, 16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0010,
    16'h0030, 16'h0040, 16'h0050, 16'h0100, 16'h0020, 16'h0000, 16'h0003};
  logic [7:0]  rf_a[5] = '{8'h01, 8'h07, 8'h01, 8'h01, 8'h01};
  logic [7:0]  rf_f[5] = '{8'h03, 8'h03, 8'h04, 8'h03, 8'h03};
  logic [15:0] rf_c[5] = '{16'h0001, 16'h0001, 16'h0001, 16'h0000, 16'h007E};
  logic        rf_b[5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  mrs_status_slave #(.BIT_CYCLES(BITC), .GAP_CYCLES(GAPC)) u_dut (
    .mclk(mclk), .rst(rst), .rxd(rxd), .txd(txd), .tx_enable(tx_enable),
    .addr_load(addr_load), .addr_value(addr_value), .slave_addr(slave_addr),
    .epoch_seconds(epoch_seconds), .epoch_valid(epoch_valid), .motor(motor),
    .motor_valid(motor_valid), .battery_dv(battery_dv), .charge_valid(charge_valid),
    .cond(cond));
  mrs_master_model #(.BIT_CYCLES(BITC), .GAP_CYCLES(GAPC)) u_mst (
    .mclk(mclk), .rxd(rxd), .txd(txd));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk);
      #1;
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // a clean run needs about 97000 cycles, a hang stops here
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 105000) begin
      errors++;
      results();
    end
  end
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [15:0] exp_of(input int idx);
    case (idx)
      4: return epoch_seconds[31:16];
      5: return epoch_seconds[15:0];
      7: return {12'h000, cond.out_of_range_fault, cond.motor_comm_err, cond.charge_comm_err, 1'b0};
      9: return hc_exp;
      10: return mot_held.speed_centi_rpm;
      11: return {14'h0000, mot_held.direction};
      12: return mot_held.current_ma;
      13: return battery_dv;
      default: return 16'h0000;
    endcase
  endfunction
  task automatic read_regs(input logic [7:0] a, input logic [7:0] f, input logic [15:0] st,
                           input logic [15:0] cnt, input logic bad, input int pause);
    logic [7:0] r[$];
    u_mst.send_req(a, f, st, cnt, bad, pause);
    u_mst.get_reply(r);
    rlen = r.size();
    words = {};
    if (rlen < 5) return;
    chk8("reply address", a, r[0]);
    chk8("reply function", 8'h03, r[1]);
    chk8("byte count", 8'(cnt * 2), r[2]);
    chk16("reply crc residue", 16'h0000, u_mst.crc16(r));
    for (int i = 3; i < rlen - 2; i += 2) words.push_back({r[i], r[i + 1]});
  endtask
  task automatic expect_regs(input logic [7:0] a, input logic [15:0] st,
                             input logic [15:0] cnt, input int pause);
    read_regs(a, 8'h03, st, cnt, 1'b0, pause);
    chk16("register count", cnt, 16'(words.size()));
    foreach (words[i]) chk16($sformatf("register %0d", st + i), exp_of(st + i), words[i]);
  endtask
  initial begin
    rst = 1'b1;
    addr_load = 1'b0;
    addr_value = 8'h00;
    epoch_seconds = 32'h6543_21A9;
    epoch_valid = 1'b0;
    motor = '{speed_centi_rpm: 16'h0BB8, direction: 2'h1, current_ma: 16'h01F4};
    motor_valid = 1'b0;
    battery_dv = 16'h0082;
    charge_valid = 1'b0;
    cond = '0;
    hc_exp = 16'h0000;
    tick(3);
    rst = 1'b0;
    tick(20);
    chk8("address after reset", 8'h01, slave_addr);
    epoch_valid = 1'b1;
    motor_valid = 1'b1;
    charge_valid = 1'b1;
    mot_held = motor;
    tick(20);
    expect_regs(8'h01, 16'h0000, 16'h000E, 0);
    for (int i = 0; i < 3; i++) begin
      motor.direction = dirs[i];
      mot_held = motor;
      epoch_seconds = epoch_seconds + 32'h0000_0001;
      tick(20);
      expect_regs(8'h01, 16'h0005, 16'h0007, 0);
    end
    // one condition at a time, then three status bits together
    for (int i = 0; i < 13; i++) begin
      cond = mrs_cond_s'(i < 12 ? 12'h800 >> i : 12'h181);
      hc_exp = hcode[i];
      tick(20);
      expect_regs(8'h01, 16'h0007, 16'h0003, 0);
    end
    cond = mrs_cond_s'(12'h100);
    hc_exp = 16'h0003;
    motor_valid = 1'b0;
    motor.speed_centi_rpm = 16'h1111;
    tick(20);
    expect_regs(8'h01, 16'h0007, 16'h0004, 0);
    for (int i = 0; i < 5; i++) begin
      read_regs(rf_a[i], rf_f[i], 16'h0000, rf_c[i], rf_b[i], 0);
      chk16("silent reply bytes", 16'h0000, 16'(rlen));
    end
    addr_value = 8'h07;
    addr_load = 1'b1;
    tick(1);
    addr_load = 1'b0;
    chk8("loaded address", 8'h07, slave_addr);
    expect_regs(8'h07, 16'h0009, 16'h0001, 0);
    read_regs(8'h01, 8'h03, 16'h0009, 16'h0001, 1'b0, 0);
    chk16("old address reply bytes", 16'h0000, 16'(rlen));
    rst = 1'b1;
    tick(3);
    rst = 1'b0;
    mot_held = '0;
    tick(20);
    chk8("address after second reset", 8'h01, slave_addr);
    expect_regs(8'h01, 16'h0004, 16'h0002, GAPC / 2);
    results();
  end
endmodule
`default_nettype wire
